// ### pkg/hpb_pkg.sv
// Purpose: shared constants and carriers of the host port / packet buffer block
// Assumes: 40 MHz clk_sys, byte-wide packet storage of 16K
// Notes: register indices are reached through the index/data port pair
package hpb_pkg;
   // ************************************************************
   // register indices
   // ************************************************************
   localparam logic [7:0] REG_TX_CTRL = 8'h02;    // transmit control
   localparam logic [7:0] REG_TX_STAT1 = 8'h03;   // status of slot one
   localparam logic [7:0] REG_TX_STAT2 = 8'h04;   // status of slot two
   localparam logic [7:0] REG_TX_LEN_LO = 8'hFC;  // transmit length low
   localparam logic [7:0] REG_TX_LEN_HI = 8'hFD;  // transmit length high
   localparam logic [7:0] REG_MEM_READ = 8'hF2;   // memory read command
   localparam logic [7:0] REG_MEM_ADDR_LO = 8'hF4; // memory address low
   localparam logic [7:0] REG_MEM_ADDR_HI = 8'hF5; // memory address high
   localparam logic [7:0] REG_RX_PTR_LO = 8'hF6;  // receive write pointer low
   localparam logic [7:0] REG_RX_PTR_HI = 8'hF7;  // receive write pointer high
   localparam logic [7:0] REG_MEM_WRITE = 8'hF8;  // memory write command
   localparam logic [7:0] REG_IMR = 8'hFF;        // interrupt_mask_reg
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int IMR_WRAP_BIT = 7;      // address wrap enable
   localparam int TXC_REQ_BIT = 1;       // transmit request
   localparam int TXC_PAD_DIS_BIT = 2;   // pad insertion disable
   localparam int TXC_CRC_DIS_BIT = 3;   // crc insertion disable
   // ************************************************************
   // memory map
   // ************************************************************
   localparam int ADDR_W = 14;                        // byte address width
   localparam int MEM_BYTES = 16384;                  // whole packet memory
   localparam logic [ADDR_W:0] MEM_END = 15'h4000;    // end of memory
   localparam logic [ADDR_W:0] TX_END = 15'h0C00;     // end of transmit area
   localparam logic [ADDR_W-1:0] RX_START = 14'h0C00; // start of receive ring
   localparam logic [ADDR_W-1:0] TX_START = 14'h0000; // transmit start
   localparam logic [7:0] RX_MARK = 8'h01;            // header marker byte
   localparam logic [ADDR_W-1:0] RX_HDR_LEN = 14'h0004; // header bytes
   localparam logic [1:0] HDR_LAST = 2'h3;            // last header byte index
   localparam logic [7:0] RESET_BYTE = 8'h00;         // reset value of bytes
   // ************************************************************
   // carriers
   // ************************************************************
   // one write into packet memory, two byte lanes
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0] data;
      logic [1:0] be;
   } hpb_mem_wr_t;
   // one captured host access
   typedef struct packed {
      logic cmd;
      logic [15:0] data;
   } hpb_host_req_t;
endpackage : hpb_pkg

// ### rtl/hpb_pkt_mem.sv
// Purpose: flip-flop packet storage with two byte lanes
// Assumes: single write port, combinational read of two bytes
// Notes: the upper byte wraps at the end of memory
`timescale 1ns/10ps
module hpb_pkt_mem #(
   parameter int DEPTH = hpb_pkg::MEM_BYTES
) (
   input wire logic clk_sys,
   input wire logic clk_en,
   input wire hpb_pkg::hpb_mem_wr_t wr,
   input wire logic [hpb_pkg::ADDR_W-1:0] rd_addr,
   output logic [15:0] rd_data
);
   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0] mem_q [DEPTH];                   // byte cells
   logic [hpb_pkg::ADDR_W-1:0] rd_addr_hi;      // second byte address
   logic [hpb_pkg::ADDR_W-1:0] wr_addr_hi;      // second lane address

   assign rd_addr_hi = rd_addr + 14'h0001;
   assign wr_addr_hi = wr.addr + 14'h0001;
   // read two neighbouring bytes
   assign rd_data = {mem_q[rd_addr_hi], mem_q[rd_addr]};

   // both byte lanes in one process, so the cells have a single driver
   always_ff @(posedge clk_sys) begin
      for (int g = 0; g < 2; g++) begin
         // lane write when enabled
         if (clk_en && wr.be[g]) begin
            mem_q[(g == 0) ? wr.addr : wr_addr_hi] <= wr.data[8*g +: 8];
         end
      end
   end
endmodule : hpb_pkt_mem

// ### rtl/hpb_rx_writer.sv
// Purpose: stores received packets into the receive ring with a header
// Assumes: bytes arrive with valid/ready, last flagged on the final byte
// Notes: header is written after the data, once the count is known
`timescale 1ns/10ps
module hpb_rx_writer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic bus16,
   input wire logic grant,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic [7:0] rx_status,
   output logic rx_ready,
   output hpb_pkg::hpb_mem_wr_t wr,
   output logic [hpb_pkg::ADDR_W-1:0] wp_q
);
   typedef enum logic {S_DATA, S_HDR} hpb_rx_state_t;

   hpb_rx_state_t state_q, state_d;                   // writer phase
   logic [hpb_pkg::ADDR_W-1:0] wp_d;                  // packet start
   logic [hpb_pkg::ADDR_W-1:0] cnt_q, cnt_d;          // data bytes so far
   logic [7:0] stat_q, stat_d;                        // held status byte
   logic [1:0] hidx_q, hidx_d;                        // header byte index
   logic [hpb_pkg::ADDR_W-1:0] nxt;                   // next packet start
   logic [7:0] hbyte;                                 // header byte out

   // add inside the ring, folding back to the ring start
   function automatic logic [hpb_pkg::ADDR_W-1:0] ring_add(
      input logic [hpb_pkg::ADDR_W-1:0] base,
      input logic [hpb_pkg::ADDR_W-1:0] off
   );
      logic [hpb_pkg::ADDR_W:0] s;
      s = {1'b0, base} + {1'b0, off};
      if (s >= hpb_pkg::MEM_END) begin
         s = s - hpb_pkg::MEM_END + {1'b0, hpb_pkg::RX_START};
      end
      return s[hpb_pkg::ADDR_W-1:0];
   endfunction : ring_add

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      state_d = state_q;
      wp_d = wp_q;
      cnt_d = cnt_q;
      stat_d = stat_q;
      hidx_d = hidx_q;
      wr = '0;
      rx_ready = (state_q == S_DATA) && grant;
      case (hidx_q)
         2'h0: hbyte = hpb_pkg::RX_MARK;
         2'h1: hbyte = stat_q;
         2'h2: hbyte = cnt_q[7:0];
         default: hbyte = {2'h0, cnt_q[hpb_pkg::ADDR_W-1:8]};
      endcase
      // align next start to bus width
      nxt = ring_add(wp_q, hpb_pkg::RX_HDR_LEN + cnt_q);
      if (bus16 && nxt[0]) begin
         nxt = ring_add(nxt, 14'h0001);
      end
      case (state_q)
         S_DATA: begin
            // data after header in the ring
            if (rx_valid && rx_ready) begin
               wr.addr = ring_add(wp_q, hpb_pkg::RX_HDR_LEN + cnt_q);
               wr.data = {8'h00, rx_data};
               wr.be = 2'b01;
               cnt_d = cnt_q + 14'h0001;
               if (rx_last) begin
                  stat_d = rx_status;
                  hidx_d = 2'h0;
                  state_d = S_HDR;
               end
            end
         end
         S_HDR: begin
            if (grant) begin
               wr.addr = ring_add(wp_q, {12'h000, hidx_q});
               wr.data = {8'h00, hbyte};
               wr.be = 2'b01;
               hidx_d = hidx_q + 2'h1;
               if (hidx_q == hpb_pkg::HDR_LAST) begin
                  wp_d = nxt;
                  cnt_d = '0;
                  state_d = S_DATA;
               end
            end
         end
         default: state_d = S_DATA;
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= S_DATA;
         wp_q <= hpb_pkg::RX_START;
         cnt_q <= '0;
         stat_q <= hpb_pkg::RESET_BYTE;
         hidx_q <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         wp_q <= wp_d;
         cnt_q <= cnt_d;
         stat_q <= stat_d;
         hidx_q <= hidx_d;
      end
   end
endmodule : hpb_rx_writer

// ### rtl/hpb_host_port.sv
// Purpose: host index/data port, sequential packet memory access, transmit slots
// Assumes: host pins are asynchronous and pass two flip-flops
// Notes: reads act at strobe assertion, writes at strobe release
//
// Contract
// - chip select qualifies access, polarity settable
// - port select low index, high data
// - dummy command loads buffer, data discarded
// - advance by bus width, prefetch next
// - 16K memory, 3K transmit, 13K receive
// - write wrap to zero at 3K
// - read wrap to 0x0C00 at 16K
// - two transmit slots used alternately
// - control register, two slot status registers
// - reset: start zero, slot one current
// - next count and request after completion
// - receive ring starts at 0C00h
// - four byte header before packet data
// - packet start aligned to bus width
`timescale 1ns/10ps
module hpb_host_port #(
   parameter int DEPTH = hpb_pkg::MEM_BYTES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cs_pin,
   input wire logic cs_active_high,
   input wire logic cmd_pin,
   input wire logic rd_n_pin,
   input wire logic wr_n_pin,
   input wire logic [15:0] sd_in,
   output logic [15:0] sd_out,
   output logic sd_oe_n,
   input wire logic bus16,
   output logic tx_start,
   output logic tx_slot,
   output logic [hpb_pkg::ADDR_W-1:0] tx_base,
   output logic [15:0] tx_len,
   output logic tx_crc_dis,
   output logic tx_pad_dis,
   input wire logic tx_done,
   input wire logic [7:0] tx_status,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic [7:0] rx_status,
   output logic rx_ready
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [19:0] pin_m_q;    // first stage, read only by second stage
   logic [19:0] pin_s_q;    // second stage
   logic cs_s, cmd_s, rd_n_s, wr_n_s;
   logic [15:0] sd_s;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_m_q <= 20'hFFFFF;
         pin_s_q <= 20'hFFFFF;
      end else if (clk_en) begin
         pin_m_q <= {cs_pin, cmd_pin, rd_n_pin, wr_n_pin, sd_in};
         pin_s_q <= pin_m_q;
      end
   end
   assign {cs_s, cmd_s, rd_n_s, wr_n_s, sd_s} = pin_s_q;

   // ************************************************************
   // access detection
   // ************************************************************
   logic cs_ok;                      // chip selected
   logic rd_act, wr_act;             // qualified strobes
   logic rd_prev_q, wr_prev_q;       // strobe history
   logic rd_go, wr_go;               // one-cycle access events
   hpb_pkg::hpb_host_req_t req_q, req_d; // held write fields

   assign cs_ok = cs_active_high ? cs_s : ~cs_s;
   assign rd_act = cs_ok && !rd_n_s;
   assign wr_act = cs_ok && !wr_n_s;
   assign rd_go = rd_act && !rd_prev_q;
   assign wr_go = wr_prev_q && !wr_act;
   // drive the data pins while a read strobe stands
   assign sd_oe_n = ~rd_act;

   // hold the fields of a write while its strobe stands
   always_comb begin
      req_d = req_q;
      if (wr_act) begin
         req_d.cmd = cmd_s;
         req_d.data = sd_s;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         req_q <= '0;
      end else if (clk_en) begin
         rd_prev_q <= rd_act;
         wr_prev_q <= wr_act;
         req_q <= req_d;
      end
   end

   // ************************************************************
   // register file and memory access state
   // ************************************************************
   logic [7:0] index_q, index_d;                  // selected register
   logic [7:0] imr_q, imr_d;                      // wrap enable and mask
   logic [7:0] txc_q, txc_d;                      // transmit control
   logic [7:0] stat1_q, stat1_d;                  // slot one status
   logic [7:0] stat2_q, stat2_d;                  // slot two status
   logic [15:0] len_q, len_d;                     // transmit length
   logic [hpb_pkg::ADDR_W-1:0] maddr_q, maddr_d;  // memory pointer
   logic [15:0] buf_q, buf_d;                     // prefetch buffer
   logic first_q, first_d;                        // next command is dummy
   logic slot_q, slot_d;                          // current slot, 0 = one
   logic [hpb_pkg::ADDR_W-1:0] base_q, base_d;    // current slot start
   logic start_q, start_d;                        // transmit start pulse
   logic pf_q; // pointer moved last cycle, refill buffer
   logic [15:0] dout_q, dout_d;                   // read data to pins
   logic [hpb_pkg::ADDR_W-1:0] step;              // bus width in bytes
   logic [hpb_pkg::ADDR_W:0] adv;                 // advanced pointer
   logic [15:0] mem_rd;                           // storage read data
   logic [hpb_pkg::ADDR_W-1:0] rx_wp;             // receive pointer
   hpb_pkg::hpb_mem_wr_t host_wr, rx_wr, mem_wr;  // write requests
   logic host_mem_wr;                             // host owns write port
   logic is_rd_cmd, is_wr_cmd;                    // memory commands

   assign step = bus16 ? 14'h0002 : 14'h0001;
   // only the data port reaches commands
   assign is_rd_cmd = rd_go && cmd_s && (index_q == hpb_pkg::REG_MEM_READ);
   assign is_wr_cmd = wr_go && req_q.cmd && (index_q == hpb_pkg::REG_MEM_WRITE);

   // next values of the register group
   always_comb begin
      index_d = index_q;
      imr_d = imr_q;
      txc_d = txc_q;
      stat1_d = stat1_q;
      stat2_d = stat2_q;
      len_d = len_q;
      maddr_d = maddr_q;
      // refill from the new location after an advance
      buf_d = pf_q ? mem_rd : buf_q;
      first_d = first_q;
      slot_d = slot_q;
      base_d = base_q;
      start_d = 1'b0;
      dout_d = dout_q;
      host_wr = '0;
      adv = {1'b0, maddr_q} + {1'b0, step};
      // write wrap at transmit area end
      if (is_wr_cmd && imr_q[hpb_pkg::IMR_WRAP_BIT] && adv >= hpb_pkg::TX_END) begin
         adv = '0;
      end
      // read wrap back to receive start
      if (is_rd_cmd && imr_q[hpb_pkg::IMR_WRAP_BIT] && adv >= hpb_pkg::MEM_END) begin
         adv = {1'b0, hpb_pkg::RX_START};
      end
      if (adv >= hpb_pkg::MEM_END) begin
         adv = adv - hpb_pkg::MEM_END;
      end
      if (tx_done && txc_q[hpb_pkg::TXC_REQ_BIT]) begin
         txc_d[hpb_pkg::TXC_REQ_BIT] = 1'b0;
         if (slot_q) begin
            stat2_d = tx_status;
         end else begin
            stat1_d = tx_status;
         end
         slot_d = ~slot_q;
         base_d = (({1'b0, base_q} + {1'b0, len_q[hpb_pkg::ADDR_W-1:0]}) >= hpb_pkg::TX_END)
                  ? hpb_pkg::TX_START : base_q + len_q[hpb_pkg::ADDR_W-1:0];
      end
      // reads: register mux into the pin data register
      if (rd_go) begin
         if (!cmd_s) begin
            dout_d = {8'h00, index_q};
         end else begin
            case (index_q)
               hpb_pkg::REG_TX_CTRL: dout_d = {8'h00, txc_q};
               hpb_pkg::REG_TX_STAT1: dout_d = {8'h00, stat1_q};
               hpb_pkg::REG_TX_STAT2: dout_d = {8'h00, stat2_q};
               hpb_pkg::REG_TX_LEN_LO: dout_d = {8'h00, len_q[7:0]};
               hpb_pkg::REG_TX_LEN_HI: dout_d = {8'h00, len_q[15:8]};
               hpb_pkg::REG_MEM_ADDR_LO: dout_d = {8'h00, maddr_q[7:0]};
               hpb_pkg::REG_MEM_ADDR_HI: dout_d = {10'h000, maddr_q[13:8]};
               hpb_pkg::REG_RX_PTR_LO: dout_d = {8'h00, rx_wp[7:0]};
               hpb_pkg::REG_RX_PTR_HI: dout_d = {10'h000, rx_wp[13:8]};
               hpb_pkg::REG_IMR: dout_d = {8'h00, imr_q};
               hpb_pkg::REG_MEM_READ: dout_d = bus16 ? buf_q : {8'h00, buf_q[7:0]};
               default: dout_d = 16'h0000;
            endcase
         end
      end
      // memory read command: dummy loads, later ones advance and prefetch
      if (is_rd_cmd) begin
         if (first_q) begin
            buf_d = mem_rd;
            first_d = 1'b0;
         end else begin
            // advance, the refill follows next cycle
            maddr_d = adv[hpb_pkg::ADDR_W-1:0];
         end
      end
      // writes at strobe release
      if (wr_go) begin
         if (!req_q.cmd) begin
            index_d = req_q.data[7:0];
         end else begin
            case (index_q)
               hpb_pkg::REG_TX_CTRL: begin
                  txc_d = req_q.data[7:0];
                  // request held while one is running
                  if (txc_q[hpb_pkg::TXC_REQ_BIT]) begin
                     txc_d[hpb_pkg::TXC_REQ_BIT] = 1'b1;
                  end else begin
                     start_d = req_q.data[hpb_pkg::TXC_REQ_BIT];
                  end
               end
               hpb_pkg::REG_TX_LEN_LO: len_d[7:0] = req_q.data[7:0];
               hpb_pkg::REG_TX_LEN_HI: len_d[15:8] = req_q.data[7:0];
               hpb_pkg::REG_MEM_ADDR_LO: begin
                  maddr_d[7:0] = req_q.data[7:0];
                  first_d = 1'b1;
               end
               hpb_pkg::REG_MEM_ADDR_HI: begin
                  maddr_d[13:8] = req_q.data[5:0];
                  first_d = 1'b1;
               end
               hpb_pkg::REG_IMR: imr_d = req_q.data[7:0];
               hpb_pkg::REG_MEM_WRITE: begin
                  if (first_q) begin
                     buf_d = mem_rd;
                     first_d = 1'b0;
                  end else begin
                     host_wr.addr = maddr_q;
                     host_wr.data = req_q.data;
                     host_wr.be = bus16 ? 2'b11 : 2'b01;
                     maddr_d = adv[hpb_pkg::ADDR_W-1:0];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ************************************************************
   // register group flip-flops
   // ************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         index_q <= hpb_pkg::RESET_BYTE;
         imr_q <= hpb_pkg::RESET_BYTE;
         txc_q <= hpb_pkg::RESET_BYTE;
         stat1_q <= hpb_pkg::RESET_BYTE;
         stat2_q <= hpb_pkg::RESET_BYTE;
         len_q <= '0;
         maddr_q <= '0;
         buf_q <= '0;
         first_q <= 1'b1;
         slot_q <= 1'b0;
         base_q <= hpb_pkg::TX_START;
         start_q <= 1'b0;
         dout_q <= '0;
      end else if (clk_en) begin
         index_q <= index_d;
         imr_q <= imr_d;
         txc_q <= txc_d;
         stat1_q <= stat1_d;
         stat2_q <= stat2_d;
         len_q <= len_d;
         maddr_q <= maddr_d;
         // prefetch of the new location lands one cycle after the advance
         buf_q <= buf_d;
         first_q <= first_d;
         slot_q <= slot_d;
         base_q <= base_d;
         start_q <= start_d;
         dout_q <= dout_d;
      end
   end

   // ************************************************************
   // prefetch after advance
   // ************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pf_q <= 1'b0;
      end else if (clk_en) begin
         pf_q <= (is_rd_cmd || is_wr_cmd) && !first_q;
      end
   end

   // ************************************************************
   // outputs and storage
   // ************************************************************
   assign sd_out = dout_q;
   assign tx_start = start_q;
   assign tx_slot = slot_q;
   assign tx_base = base_q;
   assign tx_len = len_q;
   // crc and pad control from control register
   assign tx_crc_dis = txc_q[hpb_pkg::TXC_CRC_DIS_BIT];
   assign tx_pad_dis = txc_q[hpb_pkg::TXC_PAD_DIS_BIT];

   // host writes take the port, receive stalls
   assign host_mem_wr = |host_wr.be;
   assign mem_wr = host_mem_wr ? host_wr : rx_wr;

   // one 16K store shared by both areas
   hpb_pkt_mem #(
      .DEPTH(DEPTH)
   ) u_mem (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .wr(mem_wr),
      .rd_addr(maddr_q),
      .rd_data(mem_rd)
   );

   hpb_rx_writer u_rx (
      .clk_sys(clk_sys),
      .rst(rst),
      .clk_en(clk_en),
      .bus16(bus16),
      .grant(~host_mem_wr),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .rx_last(rx_last),
      .rx_status(rx_status),
      .rx_ready(rx_ready),
      .wr(rx_wr),
      .wp_q(rx_wp)
   );
endmodule : hpb_host_port

// ### test/hpb_host_port_asserts.sv
// Purpose: port checker of hpb_host_port
// Assumes: one clock domain, async active high reset
// Notes: bound from the testbench top file
`timescale 1ns/10ps
module hpb_host_port_asserts (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cs_pin,
   input wire logic cs_active_high,
   input wire logic rd_n_pin,
   input wire logic wr_n_pin,
   input wire logic [15:0] sd_out,
   input wire logic sd_oe_n,
   input wire logic tx_start,
   input wire logic tx_slot,
   input wire logic [13:0] tx_base,
   input wire logic tx_done
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ************
   // port relations
   // ************
   AST_OE_SEL: assert property (!sd_oe_n |-> !$past(rd_n_pin, 2) && $past(cs_pin, 2) == cs_active_high) else $error("data pins driven without selected read");
   AST_OUT_CHG: assert property ($changed(sd_out) |-> !$past(rd_n_pin, 2) || !$past(rd_n_pin, 3) || !$past(rd_n_pin, 4)) else $error("read data changed without a read");
   AST_START_PULSE: assert property (tx_start |=> !tx_start) else $error("start longer than one cycle");
   AST_SLOT_CHG: assert property ($changed(tx_slot) |-> $past(tx_done)) else $error("slot changed without completion");
   AST_START_SLOT: assert property (tx_start |-> $stable(tx_slot)) else $error("slot moved at start");
   AST_BASE_RANGE: assert property (tx_base < 14'h0C00) else $error("transmit base outside transmit area");
   AST_BASE_CHG: assert property ($changed(tx_base) |-> $past(tx_done)) else $error("base moved without completion");
   AST_START_WR: assert property (tx_start |-> !$past(wr_n_pin, 3) || !$past(wr_n_pin, 4) || !$past(wr_n_pin, 5) || !$past(wr_n_pin, 6)) else $error("start without host write");
   COV_READ: cover property (!sd_oe_n);
   COV_START: cover property (tx_start);
   COV_SWAP: cover property ($changed(tx_slot));
endmodule : hpb_host_port_asserts

// ### test/hpb_tx_model.sv
// Purpose: transmitter standing beyond the slot outputs
// Assumes: a start is answered after a fixed delay
// Notes: status byte is an arbitrary pattern
`timescale 1ns/10ps
module hpb_tx_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tx_start,
   output logic tx_done,
   output logic [7:0] tx_status
);
   logic [3:0] cnt_q; // cycles left in the frame
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) cnt_q <= 4'h0;
      else if (tx_start) cnt_q <= 4'h9;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   assign tx_done = (cnt_q == 4'h1);
   assign tx_status = tx_done ? 8'h3C : 8'hC3; // junk outside the pulse
endmodule : hpb_tx_model

// ### test/hpb_host_port_tb.sv
// Purpose: self-checking bench of hpb_host_port
// Assumes: 8-bit mode, chip select active low
// Notes: pins change at the falling edge
`timescale 1ns/10ps
module hpb_host_port_tb;
   logic clk_sys = 1'b0, rst = 1'b1, cs_pin = 1'b1, cmd_pin = 1'b0, rd_n_pin = 1'b1;
   logic wr_n_pin = 1'b1, tx_start, tx_slot, tx_done, sd_oe_n, rx_ready, crc_dis, pad_dis;
   logic rx_valid = 1'b0, rx_last = 1'b0;
   logic [15:0] sd_in = 16'h0000, sd_out, tx_len, rdv;
   logic [13:0] tx_base;
   logic [7:0] tx_status, rx_data = 8'h00, rx_status = 8'h00;
   int bad_count = 0, checks_done = 0, n;
   always #12.5 clk_sys = ~clk_sys;
   hpb_host_port hpb_host_port_i (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .cs_pin(cs_pin),
      .cs_active_high(1'b0), .cmd_pin(cmd_pin), .rd_n_pin(rd_n_pin), .wr_n_pin(wr_n_pin),
      .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n), .bus16(1'b0), .tx_start(tx_start),
      .tx_slot(tx_slot), .tx_base(tx_base), .tx_len(tx_len), .tx_crc_dis(crc_dis),
      .tx_pad_dis(pad_dis), .tx_done(tx_done), .tx_status(tx_status), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_status(rx_status), .rx_ready(rx_ready));
   hpb_tx_model hpb_tx_model_i (.clk_sys(clk_sys), .rst(rst), .tx_start(tx_start),
      .tx_done(tx_done), .tx_status(tx_status));
   task automatic complete_run;
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
         bad_count++;
      end
   endtask : chk
   // one strobe, held six cycles, then four idle
   task automatic acc(input logic c, input logic w, input logic [15:0] d);
      cs_pin = 1'b0; cmd_pin = c; sd_in = d; rd_n_pin = w; wr_n_pin = !w;
      repeat (6) @(negedge clk_sys);
      rdv = {8'h00, sd_out[7:0]};
      rd_n_pin = 1'b1; wr_n_pin = 1'b1; cs_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
   endtask : acc
   // one receive byte, held until the writer takes it
   task automatic rxb(input logic [7:0] d, input logic l);
      rx_valid = 1'b1; rx_data = d; rx_last = l; rx_status = 8'h5E;
      for (n = 0; n < 8 && rx_ready !== 1'b1; n++) @(negedge clk_sys);
      if (n == 8) begin
         $display("CHECK FAILED %0t receive byte not taken", $time);
         bad_count++;
      end
      @(negedge clk_sys);
   endtask : rxb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, {8'h00, a}); acc(1'b1, 1'b1, {8'h00, d});
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, {8'h00, a}); acc(1'b1, 1'b0, 16'h0000); chk(rdv, {8'h00, e});
   endtask : rdc
   initial begin
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk({15'h0000, tx_slot}, 16'h0000);
      chk({2'h0, tx_base}, 16'h0000);
      rdc(8'hF7, 8'h0C);
      rdc(8'hF6, 8'h00);
      rdc(8'h50, 8'h00);
      wr(8'hF4, 8'h00); wr(8'hF5, 8'h00); acc(1'b0, 1'b1, 16'h00F8);
      acc(1'b1, 1'b1, 16'h0011); acc(1'b1, 1'b1, 16'h00A5); acc(1'b1, 1'b1, 16'h005A);
      wr(8'hF4, 8'h00); wr(8'hF5, 8'h00); acc(1'b0, 1'b1, 16'h00F2);
      acc(1'b1, 1'b0, 16'h0000);
      acc(1'b1, 1'b0, 16'h0000); chk(rdv, 16'h00A5);
      acc(1'b1, 1'b0, 16'h0000); chk(rdv, 16'h005A);
      wr(8'hFC, 8'h02); wr(8'hFD, 8'h00); wr(8'h02, 8'h0E);
      chk({14'h0000, crc_dis, pad_dis}, 16'h0003);
      chk(tx_len, 16'h0002);
      for (n = 0; n < 40 && tx_slot !== 1'b1; n++) @(negedge clk_sys);
      if (n == 40) begin
         $display("CHECK FAILED %0t slot never switched", $time);
         bad_count++;
      end else begin
         chk({2'h0, tx_base}, 16'h0002);
         rdc(8'h03, 8'h3C);
         rdc(8'h02, 8'h0C);
         rxb(8'h77, 1'b0); rxb(8'h88, 1'b1); rx_valid = 1'b0;
         rdc(8'hF6, 8'h06);
         wr(8'hF4, 8'h00); wr(8'hF5, 8'h0C); acc(1'b0, 1'b1, 16'h00F2);
         acc(1'b1, 1'b0, 16'h0000);
         acc(1'b1, 1'b0, 16'h0000); chk(rdv, 16'h0001);
         acc(1'b1, 1'b0, 16'h0000); chk(rdv, 16'h005E);
         acc(1'b1, 1'b0, 16'h0000); chk(rdv, 16'h0002);
         acc(1'b1, 1'b0, 16'h0000); acc(1'b1, 1'b0, 16'h0000); chk(rdv, 16'h0077);
      end
      complete_run();
   end
endmodule : hpb_host_port_tb
bind hpb_host_port hpb_host_port_asserts hpb_host_port_asserts_i (.clk_sys(clk_sys), .rst(rst),
   .cs_pin(cs_pin), .cs_active_high(cs_active_high), .rd_n_pin(rd_n_pin), .wr_n_pin(wr_n_pin),
   .sd_out(sd_out), .sd_oe_n(sd_oe_n), .tx_start(tx_start), .tx_slot(tx_slot),
   .tx_base(tx_base), .tx_done(tx_done));
